// *** core/mbrq_defs.svh ***
// Purpose: Shared constants of the read-query handler
// Assumes: Byte-wide request and reply streams
// Notes: Definitions only
`ifndef MBRQ_DEFS_SVH
`define MBRQ_DEFS_SVH

`define MBRQ_FN_DISC 8'h02
`define MBRQ_FN_HOLD 8'h03
`define MBRQ_FN_INPUT 8'h04
`define MBRQ_EXC_FLAG 8'h80
`define MBRQ_EXC_ADDR 8'h02
`define MBRQ_EXC_VALUE 8'h03
`define MBRQ_DISC_FIRST 16'h02d8
`define MBRQ_DISC_LAST 16'h031f
`define MBRQ_DISC_BITS 72
`define MBRQ_MAX_REGS 16'h007d
`define MBRQ_REQ_LEN 4'h8
`define MBRQ_MIN_LEN 4'h4
`define MBRQ_HDR_LEN 8'h03
`define MBRQ_CRC_INIT 16'hffff
`define MBRQ_CRC_POLY 16'ha001

`endif

// *** core/mbrq_pkg.sv ***
// Purpose: Types of the read-query handler
// Assumes: Constants live in mbrq_defs.svh
// Notes: Nothing here is imported
package mbrq_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EVAL,
    ST_SEND,
    ST_DONE
  } mbrq_state_t;

  typedef struct packed {
    logic [7:0] slave;
    logic [7:0] func;
    logic [15:0] start;
    logic [15:0] count;
  } mbrq_req_t;

  typedef struct packed {
    logic [15:0] invalid_addr;
    logic [15:0] illegal_reg;
    logic [15:0] bad_packet;
  } mbrq_cnt_t;

endpackage : mbrq_pkg

// *** core/mbrq_crc16.sv ***
// Purpose: Byte-serial CRC-16 accumulator
// Assumes: One byte per enabled cycle
// Notes: Residue over a frame plus its own CRC is zero
`timescale 1ns/10ps
`default_nettype none
`include "mbrq_defs.svh"

module mbrq_crc16 (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // Control
  input wire logic clr,
  input wire logic en,
  input wire logic [7:0] data,
  // Result
  output logic [15:0] crc
);

  logic [15:0] crc_reg;
  logic [15:0] crc_next;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `MBRQ_CRC_POLY) : (r >> 1); // RULE_12
    end
    return r;
  endfunction : crc_byte

  assign crc_next = clr ? `MBRQ_CRC_INIT : (en ? crc_byte(crc_reg, data) : crc_reg);
  assign crc = crc_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      crc_reg <= `MBRQ_CRC_INIT;
    end else if (ce) begin
      crc_reg <= crc_next;
    end
  end

endmodule : mbrq_crc16
`default_nettype wire

// *** core/mbrq_handler.sv ***
// Purpose: Slave handler for discrete-input and register read queries
// Assumes: Frame boundaries are marked by rx_end from the byte layer
// Notes: Replies leave through a valid/ready byte stream
// Contract
// [RULE_01] Bits 728 to 799 map onto status rows 91 to 99, eight a row, readable by 02h only.
// [RULE_02] Discrete read errors give 02h (address) or 03h (count, format) and bump a counter.
// [RULE_03] Function 03h returns words from the configurable map, up to 125 at once.
// [RULE_04] Function 04h returns words from the same map, up to 125 at once.
// [RULE_05] The master sends address, function, two-byte start, two-byte count and CRC.
// [RULE_06] A good reply is address, function, byte count n, n data bytes and CRC.
// [RULE_07] Holding reads answer 02h or 03h with the matching counter bumped.
// [RULE_08] Input reads answer 02h or 03h with the matching counter bumped.
// [RULE_09] A master using 4X references subtracts 40001 to get the wire address.
// [RULE_10] A master using 3X references subtracts 30001 to get the wire address.
// [RULE_11] The map is loaded by a configuration port and reads return its current contents.
// [RULE_12] CRC-16 uses polynomial a001h from ffffh, low byte first, and bad frames are dropped.
// [RULE_13] An exception reply is address, function with bit 7 set, code and CRC.
`timescale 1ns/10ps
`default_nettype none
`include "mbrq_defs.svh"

module mbrq_handler #(
  parameter int MAP_DEPTH = 128,
  parameter int NQ = 16
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // Station address
  input wire logic [7:0] slave_addr,
  // Request bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_end,
  // Reply bytes
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // Map configuration
  input wire logic cfg_we,
  input wire logic [$clog2(MAP_DEPTH)-1:0] cfg_loc,
  input wire logic [$clog2(NQ)-1:0] cfg_qsel,
  // Live data
  input wire logic [NQ-1:0][15:0] qty_words,
  input wire logic [`MBRQ_DISC_BITS-1:0] elem_bits,
  // Status
  output logic busy,
  output mbrq_pkg::mbrq_cnt_t counters
);

  localparam int MW = $clog2(MAP_DEPTH);
  localparam int QW = $clog2(NQ);

  mbrq_pkg::mbrq_state_t state_reg, state_next;
  mbrq_pkg::mbrq_req_t req_reg;
  mbrq_pkg::mbrq_cnt_t cnt_reg;
  logic [7:0] rx_buf [0:7];
  logic [3:0] rx_cnt_reg;
  logic [QW-1:0] map_sel [0:MAP_DEPTH-1];
  logic [7:0] exc_reg;
  logic [7:0] nbytes_reg;
  logic [7:0] pos_reg;
  logic tx_valid_reg;
  logic [7:0] tx_data_reg;
  logic [15:0] crc;

  ////////////////////////////////////////////////////////////////////////////
  // Request decode

  wire [7:0] rq_slave = rx_buf[0];
  wire [7:0] rq_func = rx_buf[1];
  wire [15:0] rq_start = {rx_buf[2], rx_buf[3]}; // RULE_05
  wire [15:0] rq_count = {rx_buf[4], rx_buf[5]}; // RULE_05
  wire [16:0] rq_end = {1'b0, rq_start} + {1'b0, rq_count};
  wire crc_ok = (crc == 16'h0000) && (rx_cnt_reg >= `MBRQ_MIN_LEN); // RULE_12
  wire addr_ok = (rq_slave == slave_addr);
  wire is_disc = (rq_func == `MBRQ_FN_DISC);
  wire is_reg = (rq_func == `MBRQ_FN_HOLD) || (rq_func == `MBRQ_FN_INPUT); // RULE_03 RULE_04
  wire fmt_bad = (rx_cnt_reg != `MBRQ_REQ_LEN);
  wire disc_addr_bad = (rq_start < `MBRQ_DISC_FIRST) || (rq_start > `MBRQ_DISC_LAST); // RULE_01
  wire disc_cnt_bad = (rq_count == 16'h0000) ||
                      (rq_end > {1'b0, `MBRQ_DISC_LAST} + 17'h00001); // RULE_01
  wire reg_addr_bad = ({1'b0, rq_start} >= 17'(MAP_DEPTH));
  wire reg_cnt_bad = (rq_count == 16'h0000) || (rq_count > `MBRQ_MAX_REGS); // RULE_03 RULE_04
  wire reg_end_bad = (rq_end > 17'(MAP_DEPTH));
  wire reply = crc_ok && addr_ok && (is_disc || is_reg);

  // Exception code chosen for the request, zero when it is good
  wire [7:0] exc_pick =
    fmt_bad ? `MBRQ_EXC_VALUE :
    is_disc ? (disc_addr_bad ? `MBRQ_EXC_ADDR : (disc_cnt_bad ? `MBRQ_EXC_VALUE : 8'h00)) :
    reg_addr_bad ? `MBRQ_EXC_ADDR :
    reg_cnt_bad ? `MBRQ_EXC_VALUE :
    reg_end_bad ? `MBRQ_EXC_ADDR : 8'h00; // RULE_02 RULE_07 RULE_08

  // Bytes of data: one per eight bits, two per register
  wire [15:0] bits_up = rq_count + 16'h0007;
  wire [7:0] nbytes_pick = is_disc ? bits_up[10:3] : {rq_count[6:0], 1'b0}; // RULE_06

  ////////////////////////////////////////////////////////////////////////////
  // Reply byte source

  function automatic logic [7:0] disc_byte(input logic [15:0] start, input logic [15:0] count,
                                           input logic [7:0] k,
                                           input logic [`MBRQ_DISC_BITS-1:0] bits);
    logic [7:0] b;
    logic [15:0] idx;
    b = 8'h00;
    idx = 16'h0000;
    for (int j = 0; j < 8; j++) begin
      idx = {5'h00, k, 3'(j)};
      if (idx < count) begin
        b[j] = bits[7'(start - `MBRQ_DISC_FIRST + idx)]; // RULE_01
      end
    end
    return b;
  endfunction : disc_byte

  wire [7:0] body_len = exc_reg != 8'h00 ? `MBRQ_HDR_LEN : `MBRQ_HDR_LEN + nbytes_reg;
  wire [7:0] data_k = pos_reg - `MBRQ_HDR_LEN;
  wire [15:0] word_idx = req_reg.start + {9'h000, data_k[7:1]};
  wire [15:0] word_val = qty_words[map_sel[word_idx[MW-1:0]]]; // RULE_11
  wire [7:0] reg_byte = data_k[0] ? word_val[7:0] : word_val[15:8];
  wire [7:0] data_byte = (req_reg.func == `MBRQ_FN_DISC) ?
                         disc_byte(req_reg.start, req_reg.count, data_k, elem_bits) : reg_byte;
  wire [7:0] fn_byte = (exc_reg != 8'h00) ?
                       (req_reg.func | `MBRQ_EXC_FLAG) : req_reg.func; // RULE_13
  wire [7:0] len_byte = (exc_reg != 8'h00) ? exc_reg : nbytes_reg; // RULE_06 RULE_13
  wire [7:0] pay_byte = (pos_reg == 8'h00) ? req_reg.slave :
                        (pos_reg == 8'h01) ? fn_byte :
                        (pos_reg == 8'h02) ? len_byte : data_byte;
  wire [7:0] out_byte = (pos_reg < body_len) ? pay_byte :
                        (pos_reg == body_len) ? crc[7:0] : crc[15:8]; // RULE_12
  wire slot_free = !tx_valid_reg || tx_ready;
  wire tx_load = (state_reg == mbrq_pkg::ST_SEND) && slot_free && (pos_reg <= body_len + 8'h01);
  wire tx_over = (state_reg == mbrq_pkg::ST_SEND) && slot_free && (pos_reg > body_len + 8'h01);
  wire rx_take = (state_reg == mbrq_pkg::ST_IDLE) && rx_valid;

  ////////////////////////////////////////////////////////////////////////////
  // CRC shared by receive and transmit

  wire crc_clr = (state_reg == mbrq_pkg::ST_EVAL) || (state_reg == mbrq_pkg::ST_DONE);
  wire crc_en = rx_take || (tx_load && (pos_reg < body_len));
  wire [7:0] crc_din = rx_take ? rx_data : pay_byte;

  mbrq_crc16 u_crc (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .clr(crc_clr),
    .en(crc_en),
    .data(crc_din),
    .crc(crc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      mbrq_pkg::ST_IDLE: begin
        if (rx_end) begin
          state_next = mbrq_pkg::ST_EVAL;
        end
      end
      mbrq_pkg::ST_EVAL: begin
        state_next = reply ? mbrq_pkg::ST_SEND : mbrq_pkg::ST_IDLE; // RULE_12
      end
      mbrq_pkg::ST_SEND: begin
        if (tx_over) begin
          state_next = mbrq_pkg::ST_DONE;
        end
      end
      mbrq_pkg::ST_DONE: begin
        state_next = mbrq_pkg::ST_IDLE;
      end
      default: begin
        state_next = mbrq_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= mbrq_pkg::ST_IDLE;
      rx_cnt_reg <= 4'h0;
    end else if (ce) begin
      state_reg <= state_next;
      if (state_reg == mbrq_pkg::ST_EVAL) begin
        rx_cnt_reg <= 4'h0;
      end else if (rx_take && rx_cnt_reg != 4'hf) begin
        rx_cnt_reg <= rx_cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        rx_buf[i] <= 8'h00;
      end
    end else if (ce && rx_take && rx_cnt_reg < `MBRQ_REQ_LEN) begin
      rx_buf[rx_cnt_reg[2:0]] <= rx_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      req_reg <= '0;
      exc_reg <= 8'h00;
      nbytes_reg <= 8'h00;
      cnt_reg <= '0;
    end else if (ce && state_reg == mbrq_pkg::ST_EVAL && reply) begin
      req_reg <= {rq_slave, rq_func, rq_start, rq_count};
      exc_reg <= exc_pick;
      nbytes_reg <= nbytes_pick;
      if (fmt_bad) begin
        cnt_reg.bad_packet <= cnt_reg.bad_packet + 16'h0001; // RULE_02 RULE_07 RULE_08
      end else if (exc_pick == `MBRQ_EXC_ADDR) begin
        cnt_reg.invalid_addr <= cnt_reg.invalid_addr + 16'h0001; // RULE_02 RULE_07 RULE_08
      end else if (exc_pick == `MBRQ_EXC_VALUE) begin
        cnt_reg.illegal_reg <= cnt_reg.illegal_reg + 16'h0001; // RULE_02 RULE_07 RULE_08
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pos_reg <= 8'h00;
      tx_valid_reg <= 1'b0;
      tx_data_reg <= 8'h00;
    end else if (ce) begin
      if (state_reg == mbrq_pkg::ST_EVAL) begin
        pos_reg <= 8'h00;
      end else if (tx_load) begin
        pos_reg <= pos_reg + 8'h01;
        tx_data_reg <= out_byte; // RULE_06
      end
      if (tx_load) begin
        tx_valid_reg <= 1'b1;
      end else if (tx_ready) begin
        tx_valid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < MAP_DEPTH; i++) begin
        map_sel[i] <= '0;
      end
    end else if (ce && cfg_we) begin
      map_sel[cfg_loc] <= cfg_qsel; // RULE_11
    end
  end

  assign tx_valid = tx_valid_reg;
  assign tx_data = tx_data_reg;
  assign busy = (state_reg != mbrq_pkg::ST_IDLE);
  assign counters = cnt_reg;

endmodule : mbrq_handler
`default_nettype wire

// *** sim/mbrq_master_model.sv ***
// Purpose: Master polling the read-query handler
// Assumes: One request at a time, reply bytes queued in got
// Notes: slow makes the master stall every other cycle
`timescale 1ns/10ps
`default_nettype none

module mbrq_master_model (
  // Clock
  input wire logic ref_clk,
  // Request bytes
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_end,
  // Reply bytes
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  input wire logic slow
);
  logic [7:0] got[$];

  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h5a;
    rx_end = 1'b0;
    tx_ready = 1'b0;
  end

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++) begin
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
    end
    return c;
  endfunction : crc16

  task automatic send(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) begin
      @(posedge ref_clk);
      rx_valid <= 1'b1;
      rx_data <= q[i];
    end
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
    rx_end <= 1'b1;
    @(posedge ref_clk);
    rx_end <= 1'b0;
  endtask : send

  always @(posedge ref_clk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
    end
  end
endmodule : mbrq_master_model
`default_nettype wire

// *** sim/mbrq_handler_chk.sv ***
// Purpose: Port-level checks of the read-query handler
// Assumes: Sees only top-level ports
// Notes: Bound into every handler instance
`timescale 1ns/10ps
`default_nettype none

module mbrq_handler_chk #(
  parameter int MAP_DEPTH = 128,
  parameter int NQ = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Watched signals
  input wire logic [7:0] slave_addr,
  input wire logic rx_end,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic busy,
  input wire mbrq_pkg::mbrq_cnt_t counters
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [7:0] idx_reg;
  logic [7:0] fnb_reg;

  // Reply byte position and echoed function byte
  always_ff @(posedge ref_clk) begin
    if (rst || !busy) begin
      idx_reg <= 8'h00;
    end else if (tx_valid && tx_ready) begin
      idx_reg <= idx_reg + 8'h01;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (tx_valid && tx_ready && idx_reg == 8'h01) begin
      fnb_reg <= tx_data;
    end
  end

  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_hold: assert property (p_hold) else $error("reply byte moved");
  property p_quiet;
    !busy |-> !tx_valid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("reply while idle");
  property p_take;
    rx_end && !busy |=> busy;
  endproperty
  a_take: assert property (p_take) else $error("frame not taken");
  property p_first;
    $rose(tx_valid) |-> $past(rx_end, 3) && tx_data == slave_addr;
  endproperty
  a_first: assert property (p_first) else $error("bad first byte");
  property p_tail;
    $fell(tx_valid) |-> busy ##1 !busy;
  endproperty
  a_tail: assert property (p_tail) else $error("bad reply end");
  property p_fn;
    tx_valid && idx_reg == 8'h01 |-> tx_data[6:0] inside {7'h02, 7'h03, 7'h04};
  endproperty
  a_fn: assert property (p_fn) else $error("bad function echo");
  property p_code;
    tx_valid && idx_reg == 8'h02 |->
      (fnb_reg[7] ? tx_data inside {8'h02, 8'h03} : tx_data != 8'h00);
  endproperty
  a_code: assert property (p_code) else $error("bad third byte");
  property p_exlen;
    tx_valid && fnb_reg[7] && idx_reg > 8'h01 |-> idx_reg < 8'h05;
  endproperty
  a_exlen: assert property (p_exlen) else $error("long exception");
  property p_cnt;
    !$stable(counters) |-> $past(busy) && $countones({
      counters.invalid_addr != $past(counters.invalid_addr),
      counters.illegal_reg != $past(counters.illegal_reg),
      counters.bad_packet != $past(counters.bad_packet)}) == 1;
  endproperty
  a_cnt: assert property (p_cnt) else $error("counter jump");
endmodule : mbrq_handler_chk

bind mbrq_handler mbrq_handler_chk #(.MAP_DEPTH(MAP_DEPTH), .NQ(NQ)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .slave_addr(slave_addr), .rx_end(rx_end),
  .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .busy(busy),
  .counters(counters));
`default_nettype wire

// *** sim/tb_mbrq_handler.sv ***
// Purpose: Self-checking bench of the read-query handler
// Assumes: Station address 11h
// Notes: Expected replies are built here
`timescale 1ns/10ps
`default_nettype none

module tb_mbrq_handler;
  logic ref_clk, rst, cfg_we, slow, rx_valid, rx_end, tx_valid, tx_ready, busy;
  logic [7:0] rx_data, tx_data;
  logic [6:0] cfg_loc;
  logic [3:0] cfg_qsel;
  logic [15:0][15:0] qty;
  logic [71:0] elem = 72'h93_5a_c3_0f_f0_81_7e_24_d1;
  mbrq_pkg::mbrq_cnt_t cnt, exp_c;
  int n_fail, compares;
  logic [7:0] q[$], e[$];

  mbrq_handler uut (.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .slave_addr(8'h11),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .cfg_we(cfg_we), .cfg_loc(cfg_loc),
    .cfg_qsel(cfg_qsel), .qty_words(qty), .elem_bits(elem), .busy(busy), .counters(cnt));
  mbrq_master_model m (.ref_clk(ref_clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_end(rx_end), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .slow(slow));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  task automatic chk_b(input logic [7:0] g, input logic [7:0] x);
    compares++;
    if (g !== x) begin
      n_fail++;
      $display("[ERR] %0t byte %h exp %h", $time, g, x);
    end
  endtask : chk_b

  task automatic chk_c(input mbrq_pkg::mbrq_cnt_t g);
    compares++;
    if (g !== exp_c) begin
      n_fail++;
      $display("[ERR] %0t counters %h exp %h", $time, g, exp_c);
    end
  endtask : chk_c

  task automatic req(input logic [7:0] f, input logic [15:0] st, input logic [15:0] n);
    q = {8'h11, f, st[15:8], st[7:0], n[15:8], n[7:0]};
  endtask : req

  task automatic w2(input logic [15:0] w);
    e.push_back(w[15:8]);
    e.push_back(w[7:0]);
  endtask : w2

  task automatic cfg(input logic [6:0] loc, input logic [3:0] sel);
    @(posedge ref_clk);
    cfg_we <= 1'b1;
    cfg_loc <= loc;
    cfg_qsel <= sel;
    @(posedge ref_clk);
    cfg_we <= 1'b0;
  endtask : cfg

  // Sends q, then compares the whole reply with e plus its check word
  task automatic run(input logic bad);
    int k;
    logic [15:0] c;
    k = 0;
    m.got.delete();
    m.send(q, bad);
    do @(negedge ref_clk); while (busy === 1'b1 && ++k < 700);
    chk_b({7'h00, busy}, 8'h00);
    if (e.size() > 0) begin
      c = m.crc16(e);
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
    end
    chk_b(8'(m.got.size()), 8'(e.size()));
    foreach (e[i]) chk_b(m.got[i], e[i]);
    chk_c(cnt);
  endtask : run

  // which: 0 bad address, 1 bad count, 2 short frame
  task automatic err(input logic [7:0] f, input logic [15:0] st, input logic [15:0] n,
                     input int which);
    req(f, st, n);
    if (which == 2) void'(q.pop_back());
    e = {8'h11, f | 8'h80, (which == 0) ? 8'h02 : 8'h03};
    if (which == 0) exp_c.invalid_addr++;
    else if (which == 1) exp_c.illegal_reg++;
    else exp_c.bad_packet++;
    run(1'b0);
  endtask : err

  task automatic t_disc;
    req(8'h02, 16'h02d8, 16'h0048);
    e = {8'h11, 8'h02, 8'h09};
    for (int k = 0; k < 9; k++) e.push_back(elem[8*k +: 8]);
    run(1'b0);
    req(8'h02, 16'h0316, 16'h000a);
    e = {8'h11, 8'h02, 8'h02, elem[69:62], 8'(elem[71:70])};
    run(1'b0);
    err(8'h02, 16'h02d7, 16'h0001, 0);
    err(8'h02, 16'h0320, 16'h0001, 0);
    err(8'h02, 16'h0317, 16'h000a, 1);
    err(8'h02, 16'h02d8, 16'h0000, 1);
    err(8'h02, 16'h02d8, 16'h0001, 2);
  endtask : t_disc

  task automatic t_reg;
    cfg(7'h05, 4'h3);
    cfg(7'h06, 4'h9);
    req(8'h03, 16'(40006 - 40001), 16'h0002);
    e = {8'h11, 8'h03, 8'h04};
    w2(qty[3]);
    w2(qty[9]);
    run(1'b0);
    slow <= 1'b1;
    req(8'h04, 16'(30006 - 30001), 16'h0002);
    e = {8'h11, 8'h04, 8'h04};
    w2(qty[3]);
    w2(qty[9]);
    run(1'b0);
    cfg(7'h05, 4'h1);
    req(8'h04, 16'h0005, 16'h0001);
    e = {8'h11, 8'h04, 8'h02};
    w2(qty[1]);
    run(1'b0);
    slow <= 1'b0;
    req(8'h03, 16'h0000, 16'h007d);
    e = {8'h11, 8'h03, 8'hfa};
    for (int i = 0; i < 125; i++) w2(qty[(i == 5) ? 1 : (i == 6) ? 9 : 0]);
    run(1'b0);
  endtask : t_reg

  task automatic t_rerr;
    for (int j = 3; j < 5; j++) begin
      err(8'(j), 16'h0080, 16'h0001, 0);
      err(8'(j), 16'h0000, 16'h007e, 1);
      err(8'(j), 16'h0000, 16'h0000, 1);
      err(8'(j), 16'h0078, 16'h0009, 0);
      err(8'(j), 16'h0000, 16'h0001, 2);
    end
  endtask : t_rerr

  task automatic t_drop;
    e = {};
    req(8'h03, 16'h0000, 16'h0001);
    run(1'b1);
    q[0] = 8'h12;
    run(1'b0);
    req(8'h01, 16'h0000, 16'h0001);
    run(1'b0);
  endtask : t_drop

  initial begin
    rst = 1'b1;
    cfg_we = 1'b0;
    cfg_loc = 7'h00;
    cfg_qsel = 4'h0;
    slow = 1'b0;
    exp_c = '0;
    n_fail = 0;
    compares = 0;
    foreach (qty[i]) qty[i] = 16'ha5c3 ^ (16'(i) * 16'h1111);
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_disc();
    t_reg();
    t_rerr();
    t_drop();
    give_verdict();
  end

  initial begin
    #400000;
    n_fail++;
    give_verdict();
  end
endmodule : tb_mbrq_handler
`default_nettype wire
